//--- src/iprl_top.sv
// Interrupt source front end, priority arbiter and register slave
// Contract
// - Encoded pins give priority fifteen minus their value; all zero is level 15.
// - Encoded pins all high mean no request, level zero.
// - Encoded pins sampled each clock; new level taken after two equal samples.
// - In standby the filter samples on the rtc clock instead.
// - Without a running rtc clock the encoded pins cannot wake from standby.
// - Accepting these interrupts leaves the cpu mask level unchanged.
// - Sixteen port pins, levels, two groups of eight with own priority 0-15.
// - Port pin wakes standby only above mask level and with rtc running.
// - Peripheral sources have programmable priority; debug source fixed at 15.
// - Levels 0 to 16 ranked, 16 highest; level 0 masks the source.
// - Acceptance loads event codes unique per source; one common handler.
// - Reset sets every programmable priority to level 0.
// - Equal priorities resolved by a fixed default source order.
// - Non-maskable source always ranks at level 16 above all others.
// - Primary event code encodes accepted level, range 0x200 to 0x3C0. Here the nmi and debug sources load 0x1C0 and 0x5E0 instead.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module iprl_top #(
  parameter int NUM_PERIPH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt sources
  input wire logic nmi_req,
  input wire logic debug_port_source,
  input wire logic [3:0] encoded_level_pins_n,
  input wire logic [15:0] port_request_pins,
  input wire logic [NUM_PERIPH-1:0] periph_req,
  // Power state and rtc clock presence
  input wire logic standby,
  input wire logic rtc_tick,
  input wire logic rtc_running,
  // Cpu side
  input wire logic [3:0] cpu_mask_level,
  input wire logic cpu_accept,
  output logic irq_request,
  output logic [4:0] irq_level,
  output logic wake_request,
  output logic intr,
  // Axi4-lite write address and data
  input wire logic [iprl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Axi4-lite read
  input wire logic [iprl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import iprl_pkg::*;

  // ----------------------------------------------------------------
  // State and source tables
  // ----------------------------------------------------------------
  localparam int NS = 5 + NUM_PERIPH;

  typedef struct packed {
    logic [3:0] prio_lo;
    logic [3:0] prio_hi;
    logic [NUM_PERIPH*4-1:0] prio_per;
    logic [11:0] evt;
    logic [11:0] evt2;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] enable;
    logic [4:0] win_level;
    logic [11:0] win_code;
    logic [11:0] win_code2;
    logic req;
    logic wake;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iprl_state_t;

  iprl_state_t q;
  iprl_state_t next_q;
  logic [3:0] irl_filt;
  logic [4:0] irl_lvl;
  logic [4:0] src_lvl [NS];
  logic [11:0] src_code [NS];
  logic [11:0] src_code2 [NS];
  logic [4:0] best_lvl;
  logic [11:0] best_code;
  logic [11:0] best_code2;
  logic best_req;

  if (NUM_PERIPH < 1 || NUM_PERIPH > 8)
  begin : g_chk
    $error("iprl_top: NUM_PERIPH must be 1 to 8");
  end

  // Primary event code for a maskable level 1..15
  function automatic logic [11:0] level_code(input logic [4:0] lvl);
    level_code = CODE_LEVEL_BASE + {3'b000, LVL_TOP_MASKABLE - lvl[3:0], 5'b0_0000};
  endfunction : level_code

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[b*8 +: 8] = d[b*8 +: 8];
    end
    wmerge = r;
  endfunction : wmerge

  // ----------------------------------------------------------------
  // Encoded level input
  // ----------------------------------------------------------------
  iprl_filter #(
    .WIDTH(4)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .standby(standby),
    .rtc_tick(rtc_tick),
    .rtc_running(rtc_running),
    .pins(encoded_level_pins_n),
    .filtered(irl_filt)
  );

  // Level is fifteen minus pin value; all high gives zero
  assign irl_lvl = {1'b0, LVL_TOP_MASKABLE - irl_filt};

  // ----------------------------------------------------------------
  // Source levels and arbitration
  // ----------------------------------------------------------------
  // Index order is the default order, index 0 highest
  always_comb
  begin
    src_lvl[0] = nmi_req ? LVL_NMI : 5'h00;
    src_code[0] = CODE_NMI;
    src_code2[0] = CODE_NMI;
    src_lvl[1] = debug_port_source ? LVL_DEBUG : 5'h00;
    src_code[1] = CODE_DEBUG;
    src_code2[1] = CODE_DEBUG;
    src_lvl[2] = irl_lvl;
    src_code[2] = level_code(irl_lvl);
    src_code2[2] = level_code(irl_lvl);
    // Port pins as two groups, each with its own setting
    src_lvl[3] = (|port_request_pins[7:0]) ? {1'b0, q.prio_lo} : 5'h00;
    src_code[3] = level_code({1'b0, q.prio_lo});
    src_code2[3] = CODE_PORT_LO;
    src_lvl[4] = (|port_request_pins[15:8]) ? {1'b0, q.prio_hi} : 5'h00;
    src_code[4] = level_code({1'b0, q.prio_hi});
    src_code2[4] = CODE_PORT_HI;
    for (int i = 0; i < NUM_PERIPH; i++)
    begin
      src_lvl[5+i] = periph_req[i] ? {1'b0, q.prio_per[i*4 +: 4]} : 5'h00;
      src_code[5+i] = level_code({1'b0, q.prio_per[i*4 +: 4]});
      src_code2[5+i] = CODE_PERIPH_BASE + 12'(i << CODE_STEP_SHIFT);
    end
  end

  // Highest level wins; lower index wins a tie
  always_comb
  begin
    best_lvl = 5'h00;
    best_code = 12'h000;
    best_code2 = 12'h000;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (src_lvl[i] != 5'h00 && src_lvl[i] >= best_lvl)
      begin
        best_lvl = src_lvl[i];
        best_code = src_code[i];
        best_code2 = src_code2[i];
      end
    end
    best_req = best_lvl > {1'b0, cpu_mask_level};
  end

  // ----------------------------------------------------------------
  // Next state: arbiter result, events and register slave
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] word;
    logic [NUM_EVENTS-1:0] set_ev;
    logic [NUM_EVENTS-1:0] clr_ev;
    word = 32'h0000_0000;
    set_ev = '0;
    clr_ev = '0;
    next_q = q;
    next_q.win_level = best_lvl;
    next_q.win_code = best_code;
    next_q.win_code2 = best_code2;
    next_q.req = best_req;
    // Wake only above mask and with rtc clock present
    next_q.wake = standby && rtc_running && best_req;
    // Acceptance latches the codes; mask level is not touched here
    if (cpu_accept && q.req)
    begin
      next_q.evt = q.win_code;
      next_q.evt2 = q.win_code2;
      set_ev[ST_ACCEPT_BIT] = 1'b1;
    end
    set_ev[ST_WAKE_BIT] = q.wake;
    // Write channels taken in either order
    if (s_axi_awvalid && !q.aw_got && !q.bvalid)
    begin
      next_q.aw_got = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid)
    begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    // Perform the write once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      case (q.aw_addr)
        OFF_PORT_PRIO:
        begin
          word = 32'(q.prio_lo) << PORT_LO_POS | 32'(q.prio_hi) << PORT_HI_POS;
          word = wmerge(word, q.wdata, q.wstrb);
          next_q.prio_lo = word[PORT_LO_POS +: 4];
          next_q.prio_hi = word[PORT_HI_POS +: 4];
        end
        OFF_PERIPH_PRIO:
        begin
          word = wmerge(32'(q.prio_per), q.wdata, q.wstrb);
          next_q.prio_per = word[NUM_PERIPH*4-1:0];
        end
        OFF_CLEAR:
          if (q.wstrb[0])
            clr_ev = q.wdata[NUM_EVENTS-1:0];
        OFF_ENABLE:
        begin
          word = wmerge(32'(q.enable), q.wdata, q.wstrb);
          next_q.enable = word[NUM_EVENTS-1:0];
        end
        OFF_EVENT_CODE, OFF_EVENT_CODE_TWO, OFF_STATUS, OFF_LEVELS:
          next_q.bresp = RESP_OKAY;
        default:
          next_q.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready)
      next_q.bvalid = 1'b0;
    // Set wins over a clear in the same cycle
    next_q.status = (q.status & ~clr_ev) | set_ev;
    // Read answered the cycle after the address is taken
    if (q.rvalid && s_axi_rready)
      next_q.rvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid)
    begin
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFF_PORT_PRIO:
          next_q.rdata = 32'(q.prio_lo) << PORT_LO_POS | 32'(q.prio_hi) << PORT_HI_POS;
        OFF_PERIPH_PRIO: next_q.rdata = 32'(q.prio_per);
        OFF_EVENT_CODE: next_q.rdata = 32'(q.evt);
        OFF_EVENT_CODE_TWO: next_q.rdata = 32'(q.evt2);
        OFF_STATUS: next_q.rdata = 32'(q.status);
        OFF_CLEAR: next_q.rdata = 32'h0000_0000;
        OFF_ENABLE: next_q.rdata = 32'(q.enable);
        OFF_LEVELS:
          next_q.rdata = 32'(irl_lvl) << LVL_IRL_POS | 32'(q.win_level) << LVL_WIN_POS;
        default:
        begin
          next_q.rdata = 32'h0000_0000;
          next_q.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.prio_lo <= PRIO_RESET;
      q.prio_hi <= PRIO_RESET;
      q.prio_per <= {NUM_PERIPH{PRIO_RESET}};
    end
    else
    begin
      q <= next_q;
    end
  end

  // Outputs
  assign irq_request = q.req;
  assign irq_level = q.win_level;
  assign wake_request = q.wake;
  assign intr = |(q.status & q.enable);
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence irl_all_low_s;
    (encoded_level_pins_n == 4'h0 && !standby) [*3];
  endsequence
  sequence irl_all_high_s;
    (encoded_level_pins_n == 4'hF && !standby) [*3];
  endsequence

  irl_top_level_a: assert property (irl_all_low_s |-> irl_lvl == 5'h0F)
    else $error("all-low encoded pins did not give level 15");
  irl_idle_a: assert property (irl_all_high_s |-> irl_lvl == 5'h00)
    else $error("all-high encoded pins still request");
  nmi_top_a: assert property (nmi_req |=> irq_request && irq_level == 5'h10)
    else $error("nmi not at level 16");
  debug_level_a: assert property (debug_port_source |=> irq_level >= 5'h0F)
    else $error("debug source below level 15");
  above_mask_a: assert property (irq_request |-> irq_level > {1'b0, $past(cpu_mask_level)})
    else $error("request not above mask level");
  no_wake_a: assert property ((standby && !rtc_running) |=> !wake_request)
    else $error("wake without rtc clock");
  code_load_a: assert property (cpu_accept && irq_request |=> q.evt2 == $past(q.win_code2)
    && q.status[ST_ACCEPT_BIT])
    else $error("event code not loaded on acceptance");
  code_range_a: assert property (cpu_accept && irq_request && irq_level < 5'h10
    && q.win_code2 != CODE_DEBUG |=> q.evt >= CODE_LEVEL_BASE
    && q.evt <= CODE_LEVEL_LAST)
    else $error("primary event code out of range");
  reset_prio_a: assert property ($past(!aresetn) |-> q.prio_lo == PRIO_RESET
    && q.prio_hi == PRIO_RESET && q.prio_per == '0)
    else $error("priority not zero after reset");
endmodule : iprl_top

//--- src/iprl_pkg.sv
// Constants shared by the interrupt source and priority logic
package iprl_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PORT_PRIO = 8'h00;
  localparam logic [7:0] OFF_PERIPH_PRIO = 8'h04;
  localparam logic [7:0] OFF_EVENT_CODE = 8'h08;
  localparam logic [7:0] OFF_EVENT_CODE_TWO = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CLEAR = 8'h14;
  localparam logic [7:0] OFF_ENABLE = 8'h18;
  localparam logic [7:0] OFF_LEVELS = 8'h1C;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PORT_LO_POS = 12;
  localparam int PORT_HI_POS = 8;
  localparam int LVL_IRL_POS = 0;
  localparam int LVL_WIN_POS = 8;
  localparam int ST_ACCEPT_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int NUM_EVENTS = 2;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [3:0] IRL_IDLE = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------------------------------
  // Priority levels and event codes
  // ----------------------------------------------------------------
  localparam logic [4:0] LVL_NMI = 5'h10;
  localparam logic [4:0] LVL_DEBUG = 5'h0F;
  localparam logic [3:0] LVL_TOP_MASKABLE = 4'hF;
  localparam logic [11:0] CODE_NMI = 12'h1C0;
  localparam logic [11:0] CODE_DEBUG = 12'h5E0;
  localparam logic [11:0] CODE_PORT_LO = 12'h700;
  localparam logic [11:0] CODE_PORT_HI = 12'h720;
  localparam logic [11:0] CODE_PERIPH_BASE = 12'h800;
  localparam logic [11:0] CODE_LEVEL_BASE = 12'h200;
  localparam logic [11:0] CODE_LEVEL_LAST = 12'h3C0;
  localparam int CODE_STEP_SHIFT = 5;
endpackage : iprl_pkg

//--- src/iprl_filter.sv
// Two-sample noise filter for the encoded level pins
`timescale 1ns/1ps
module iprl_filter #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sampling control
  input wire logic standby,
  input wire logic rtc_tick,
  input wire logic rtc_running,
  // Pins and filtered level
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] filtered
);
  import iprl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] stable;
  } iprl_filt_t;

  iprl_filt_t q;
  iprl_filt_t next_q;
  logic sample;

  generate
    if (WIDTH != 4)
    begin : g_chk
      $error("iprl_filter: WIDTH must be 4");
    end
  endgenerate

  // Peripheral clock samples always, standby samples on the rtc tick only
  assign sample = standby ? (rtc_tick && rtc_running) : 1'b1;

  // Accept a level seen equal on two consecutive samples
  always_comb
  begin
    next_q = q;
    if (sample)
    begin
      next_q.prev = pins;
      if (pins == q.prev)
      begin
        next_q.stable = pins;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q.prev <= IRL_IDLE;
      q.stable <= IRL_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign filtered = q.stable;

  // Filtered level only moves to a value sampled twice
  filt_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(q.stable) |-> $past(pins) == $past(q.prev) && $past(sample))
    else $error("filtered level changed without two equal samples");
  // No sampling in standby between rtc ticks
  standby_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (standby && !(rtc_tick && rtc_running)) |=> $stable(q.stable))
    else $error("filter moved in standby without rtc tick");
endmodule : iprl_filter

//--- verification/iprl_cpu_model.sv
// Cpu side model that accepts a pending request once per arming
`timescale 1ns/1ps
module iprl_cpu_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Arming from bench, request from block
  input wire logic arm,
  input wire logic irq_request,
  // Acceptance pulse to block
  output logic cpu_accept
);
  logic fired;
  // One pulse while armed and requested, none again until rearmed
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !arm)
    begin
      cpu_accept <= 1'b0;
      fired <= 1'b0;
    end
    else
    begin
      cpu_accept <= irq_request && !fired;
      fired <= fired || irq_request;
    end
  end
endmodule : iprl_cpu_model

//--- verification/iprl_tb_top.sv
// Self-checking testbench for the interrupt source and priority logic
`timescale 1ns/1ps
module iprl_tb_top;
  import iprl_pkg::*;
  logic aclk, aresetn, nmi_req, debug_port_source, standby, rtc_tick, rtc_running;
  logic [3:0] encoded_level_pins_n, cpu_mask_level, s_axi_wstrb;
  logic [15:0] port_request_pins;
  logic [7:0] periph_req;
  logic cpu_accept, arm, irq_request, wake_request, intr;
  logic [4:0] irq_level;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0;
  int check_count = 0;
  // ----------------------------------------------------------------
  // Clock, block and cpu model
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  iprl_top #(.NUM_PERIPH(8)) iprl_top_i (.aclk(aclk), .aresetn(aresetn), .nmi_req(nmi_req),
    .debug_port_source(debug_port_source), .encoded_level_pins_n(encoded_level_pins_n),
    .port_request_pins(port_request_pins), .periph_req(periph_req), .standby(standby),
    .rtc_tick(rtc_tick), .rtc_running(rtc_running), .cpu_mask_level(cpu_mask_level),
    .cpu_accept(cpu_accept), .irq_request(irq_request), .irq_level(irq_level),
    .wake_request(wake_request), .intr(intr), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  iprl_cpu_model iprl_cpu_model_i (.aclk(aclk), .aresetn(aresetn), .arm(arm),
    .irq_request(irq_request), .cpu_accept(cpu_accept));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A wait ran out
  task automatic hang();
    n_mismatch++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    summarize();
  endtask : hang
  // Let edges pass, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  // Bus write, checks the response code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 40) hang();
    chk(r, er);
  endtask : wr
  // Bus read, checks data and response code
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 40) hang();
    chk(d, ed);
    chk(r, er);
  endtask : rdc
  // Arm the cpu model and wait for its acceptance pulse
  task automatic accept_now();
    int k;
    @(posedge aclk);
    arm <= 1'b1;
    for (k = 0; k < 10 && cpu_accept !== 1'b1; k++)
      @(negedge aclk);
    if (k == 10) hang();
    @(posedge aclk);
    arm <= 1'b0;
  endtask : accept_now
  // Rtc clock pulses, one cycle high each
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      rtc_tick <= 1'b1;
      @(posedge aclk);
      rtc_tick <= 1'b0;
    end
  endtask : ticks
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(OFF_PORT_PRIO, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_PERIPH_PRIO, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
    rdc(8'h40, 32'h0000_0000, RESP_SLVERR);
    wr(8'h40, 32'h0000_FFFF, RESP_SLVERR);
    wr(OFF_ENABLE, 32'h0000_0003, RESP_OKAY);
    rdc(OFF_ENABLE, 32'h0000_0003, RESP_OKAY);
  endtask : t_reset
  // Glitch, then every pin value in rising priority, then accept
  task automatic t_encoded();
    int v;
    @(posedge aclk);
    encoded_level_pins_n <= 4'h0;
    @(posedge aclk);
    encoded_level_pins_n <= IRL_IDLE;
    repeat (5)
    begin
      @(negedge aclk);
      chk(irq_request, 1'b0);
    end
    for (v = 15; v >= 0; v--)
    begin
      @(posedge aclk);
      encoded_level_pins_n <= 4'(v);
      settle(4);
      chk(irq_level, 5'(15 - v));
      chk(irq_request, 1'(v != 15));
    end
    accept_now();
    rdc(OFF_EVENT_CODE, 32'h0000_0200, RESP_OKAY);
    rdc(OFF_EVENT_CODE_TWO, 32'h0000_0200, RESP_OKAY);
    @(posedge aclk);
    encoded_level_pins_n <= IRL_IDLE;
  endtask : t_encoded
  // Masked source, mask level compare, acceptance and interrupt line
  task automatic t_periph();
    wr(OFF_CLEAR, 32'h0000_0003, RESP_OKAY);
    @(posedge aclk);
    periph_req <= 8'h01;
    cpu_mask_level <= 4'h5;
    settle(3);
    chk(irq_level, 5'h00);
    chk(irq_request, 1'b0);
    wr(OFF_PERIPH_PRIO, 32'h0000_0005, RESP_OKAY);
    settle(3);
    chk(irq_level, 5'h05);
    chk(irq_request, 1'b0);
    @(posedge aclk);
    cpu_mask_level <= 4'h4;
    settle(3);
    chk(irq_request, 1'b1);
    chk(intr, 1'b0);
    accept_now();
    rdc(OFF_EVENT_CODE, 32'h0000_0340, RESP_OKAY);
    rdc(OFF_EVENT_CODE_TWO, 32'h0000_0800, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
    chk(intr, 1'b1);
    @(posedge aclk);
    periph_req <= 8'h00;
    wr(OFF_ENABLE, 32'h0000_0000, RESP_OKAY);
    settle(1);
    chk(intr, 1'b0);
    wr(OFF_ENABLE, 32'h0000_0003, RESP_OKAY);
    settle(1);
    chk(intr, 1'b1);
    wr(OFF_CLEAR, 32'h0000_0001, RESP_OKAY);
    settle(1);
    chk(intr, 1'b0);
    rdc(OFF_CLEAR, 32'h0000_0000, RESP_OKAY);
  endtask : t_periph
  // Equal levels, port groups, debug and non-maskable sources
  task automatic t_order();
    wr(OFF_PORT_PRIO, 32'h0000_7900, RESP_OKAY);
    wr(OFF_PERIPH_PRIO, 32'h0000_0007, RESP_OKAY);
    @(posedge aclk);
    cpu_mask_level <= 4'h0;
    port_request_pins <= 16'h0008;
    periph_req <= 8'h01;
    settle(2);
    chk(irq_level, 5'h07);
    accept_now();
    rdc(OFF_EVENT_CODE_TWO, 32'h0000_0700, RESP_OKAY);
    @(posedge aclk);
    port_request_pins <= 16'h0200;
    periph_req <= 8'h00;
    settle(2);
    chk(irq_level, 5'h09);
    accept_now();
    rdc(OFF_EVENT_CODE, 32'h0000_02C0, RESP_OKAY);
    rdc(OFF_EVENT_CODE_TWO, 32'h0000_0720, RESP_OKAY);
    @(posedge aclk);
    port_request_pins <= 16'h0000;
    debug_port_source <= 1'b1;
    settle(2);
    chk(irq_level, 5'h0F);
    @(posedge aclk);
    nmi_req <= 1'b1;
    settle(2);
    chk(irq_level, 5'h10);
    accept_now();
    rdc(OFF_EVENT_CODE_TWO, 32'h0000_01C0, RESP_OKAY);
    @(posedge aclk);
    nmi_req <= 1'b0;
    debug_port_source <= 1'b0;
  endtask : t_order
  // Standby wake through the rtc-clocked filter and port pins
  task automatic t_standby();
    wr(OFF_CLEAR, 32'h0000_0003, RESP_OKAY);
    @(posedge aclk);
    standby <= 1'b1;
    cpu_mask_level <= 4'h2;
    encoded_level_pins_n <= 4'h0;
    ticks(3);
    settle(2);
    chk(wake_request, 1'b0);
    @(posedge aclk);
    rtc_running <= 1'b1;
    settle(4);
    chk(wake_request, 1'b0);
    ticks(3);
    settle(2);
    chk(wake_request, 1'b1);
    accept_now();
    @(posedge aclk);
    encoded_level_pins_n <= IRL_IDLE;
    ticks(3);
    settle(2);
    chk(wake_request, 1'b0);
    @(posedge aclk);
    rtc_running <= 1'b0;
    port_request_pins <= 16'h0001;
    settle(3);
    chk(wake_request, 1'b0);
    @(posedge aclk);
    rtc_running <= 1'b1;
    settle(3);
    chk(wake_request, 1'b1);
    @(posedge aclk);
    cpu_mask_level <= 4'h7;
    settle(3);
    chk(wake_request, 1'b0);
    @(posedge aclk);
    cpu_mask_level <= 4'h2;
    accept_now();
    @(posedge aclk);
    port_request_pins <= 16'h0000;
    standby <= 1'b0;
    rdc(OFF_STATUS, 32'h0000_0003, RESP_OKAY);
  endtask : t_standby
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {nmi_req, debug_port_source, standby, rtc_tick, rtc_running, arm} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    encoded_level_pins_n = IRL_IDLE;
    cpu_mask_level = 4'h0;
    port_request_pins = 16'h0000;
    periph_req = 8'h00;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_encoded();
    t_periph();
    t_order();
    t_standby();
    summarize();
  end
endmodule : iprl_tb_top
